/* File: hbi_host_model.sv */
// hbi_host_model: behavioural host processor on the parallel port.
// assumes link_clk is the host clock; pins move 2 ns after its rise.
`timescale 1ns/100ps
`default_nettype none
module hbi_host_model
  import hbi_pkg::*;
(
  input wire logic link_clk, // host clock
  input wire logic ready_n, // device ready, low active
  input wire logic data_oe, // device drives data bus
  input wire logic [DATA_W-1:0] data_o, // device read data
  output var hbi_pins_t pins // host pins and straps
);
  // read/write strobes and select idle high; ale and E clock idle low
  initial pins = PINS_IDLE;

  // wait n host edges, then launch the next pin change
  task automatic step(input int n);
    repeat (n) @(posedge link_clk);
    #2;
  endtask

  // straps move only while the port is held in reset
  task automatic strap(input logic [1:0] m, input logic e);
    pins.mode = m;
    pins.early = e;
  endtask

  // one access, strobe held 12 host cycles; ready delay, release delay, bus drive seen
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q, output int rdy, output int rel, output logic oe);
    rdy = -1;
    oe = 1'b0;
    pins.abus = a;
    pins.cs_n = 1'b0;
    pins.rw = ~wr;
    // mux: low byte only on the data bus, low address lines carry junk
    if (pins.mode == MODE_MUX) begin
      pins.abus = {a[15:8], ~a[7:0]};
      pins.dbus = a[7:0];
      pins.ale = 1'b1;
      step(2);
      pins.ale = 1'b0;
      step(4);
    end
    // a released bus flips rather than keep its last level
    pins.dbus = wr ? d : ~pins.dbus;
    if (pins.mode == MODE_ECLK) pins.eclk = 1'b1;
    else if (wr) pins.wr_n = 1'b0;
    else pins.rd_n = 1'b0;
    for (int i = 1; i <= 12; i++) begin
      step(1);
      if (ready_n === 1'b0 && rdy < 0) rdy = i;
      if (data_oe === 1'b1) oe = 1'b1;
    end
    q = data_o;
    pins.eclk = 1'b0;
    pins.wr_n = 1'b1;
    pins.rd_n = 1'b1;
    for (rel = 0; rel < 8 && ready_n !== 1'b1; rel++) step(1);
    step(3);
    pins.cs_n = 1'b1;
    pins.rw = 1'b1;
    pins.dbus = ~pins.dbus;
    // gap keeps write rises 6T apart and 4T after select rise
    step(6);
  endtask
endmodule // hbi_host_model
`default_nettype wire

/* File: hbi_host_port.sv */
// hbi_host_port: parallel host port onto the internal RAM.
// assumes static mode straps; host pins are sampled on link_clk.
`timescale 1ns/100ps
`default_nettype none
module hbi_host_port
  import hbi_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic reset_n, // async reset
  input wire logic ce, // clock enable
  input wire logic link_clk, // host side clock
  input wire logic [1:0] mode_sel, // bus personality strap
  input wire logic early_ready, // early ready strap
  input wire logic ale, // address latch strobe
  input wire logic read_strobe_n, // read strobe
  input wire logic write_strobe_n, // write strobe
  input wire logic chip_sel_n, // chip select
  input wire logic rw, // read/write line
  input wire logic e_clock, // E clock
  input wire logic [ABUS_W-1:0] address_bus, // address
  input wire logic [DATA_W-1:0] data_i, // data bus in
  output logic [DATA_W-1:0] data_o, // data bus out
  output logic data_oe, // data bus drive
  output logic ready_n, // ready
  output logic quarter_rate_clock_out // host clock
);
  logic rs1_q, rs2_q, rst_sys_n;
  logic lr1_q, lr2_q, rst_l_n;
  logic ce1_q, ce2_q, ce3_q, ce_link_q;
  hbi_pins_t pin_raw, pin_f, pin_p_q;
  hbi_mode_t mode;
  logic rd_fall, wr_fall, wr_rise, ale_fall, e_rise, e_fall, cs_act;
  logic launch, busy, rd_act;
  hbi_req_t launch_req, req_word_q;
  logic [LO_W-1:0] lo_addr_q;
  logic sel_q, req_q, ak1_q, ak2_q, ak_p_q, ack_rise;
  logic [DATA_W-1:0] rdata_q, rdata_sys_q;
  logic rdy_ev, rdy_arm_q, rdy_set, ready_n_q;
  logic rq1_q, rq2_q, ack_q, rq_rise;
  logic [1:0] div_q;
  logic clk_out_q;
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // reset release, one pair per domain
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_sys_n = rs2_q;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lr1_q <= 1'b0;
      lr2_q <= 1'b0;
    end else begin
      lr1_q <= 1'b1;
      lr2_q <= lr1_q;
    end
  end
  assign rst_l_n = lr2_q;

  // clock enable carried into the link domain
  always_ff @(posedge link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      ce1_q <= 1'b0;
      ce2_q <= 1'b0;
      ce3_q <= 1'b0;
      ce_link_q <= 1'b0;
    end else begin
      ce1_q <= ce;
      ce2_q <= ce1_q;
      ce3_q <= ce2_q;
      if (ce2_q == ce3_q) begin
        ce_link_q <= ce3_q;
      end
    end
  end

  // host pins, filtered; straps ride along
  assign pin_raw = {mode_sel, early_ready, ale, read_strobe_n, write_strobe_n,
                    chip_sel_n, rw, e_clock, address_bus, data_i};
  hbi_pin_filter #(.W($bits(hbi_pins_t)), .RST_VAL(PINS_IDLE)) u_pins (
    .clk(link_clk),
    .rst_n(rst_l_n),
    .en(ce_link_q),
    .d(pin_raw),
    .q(pin_f)
  );

  always_ff @(posedge link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      pin_p_q <= PINS_IDLE;
    end else if (ce_link_q) begin
      pin_p_q <= pin_f;
    end
  end

  // edges; strobe names ending _n are low active
  assign mode = hbi_mode_t'(pin_f.mode);
  assign rd_fall = pin_p_q.rd_n & ~pin_f.rd_n;
  assign wr_fall = pin_p_q.wr_n & ~pin_f.wr_n;
  assign wr_rise = ~pin_p_q.wr_n & pin_f.wr_n;
  assign ale_fall = pin_p_q.ale & ~pin_f.ale;
  assign e_rise = ~pin_p_q.eclk & pin_f.eclk;
  assign e_fall = pin_p_q.eclk & ~pin_f.eclk;
  // select may rise with the closing edge, so the sample before counts too
  assign cs_act = ~pin_f.cs_n | ~pin_p_q.cs_n;

  // low address and own select; address taken from the sample before the fall
  always_ff @(posedge link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      lo_addr_q <= 8'h00;
      sel_q <= 1'b0;
    end else if (ce_link_q && mode == MODE_MUX && ale_fall) begin
      lo_addr_q <= pin_p_q.dbus;
      sel_q <= (pin_p_q.abus[ABUS_W-1:ADDR_W] == CS_BASE);
    end
  end

  // access launch per personality; pins of other modes are not looked at
  always_comb begin
    launch = 1'b0;
    launch_req = '{we: 1'b0, addr: pin_f.abus[ADDR_W-1:0], wdata: pin_f.dbus};
    case (mode)
      MODE_MUX: begin
        launch_req.addr = {pin_f.abus[ADDR_W-1:LO_W], lo_addr_q};
        launch = sel_q & (rd_fall | wr_rise);
        launch_req.we = wr_rise;
      end
      MODE_STROBE: begin
        launch = cs_act & (rd_fall | wr_rise);
        launch_req.we = wr_rise;
      end
      MODE_ECLK: begin
        launch = cs_act & ((e_rise & pin_f.rw) | (e_fall & ~pin_f.rw));
        launch_req.we = e_fall;
      end
      default: launch = 1'b0;
    endcase
  end

  // request to the core; a launch while busy is dropped (host spacing forbids it)
  assign busy = req_q | ak2_q;
  always_ff @(posedge link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      req_q <= 1'b0;
      req_word_q <= '0;
    end else if (ce_link_q) begin
      if (launch && !busy) begin
        req_q <= 1'b1;
        req_word_q <= launch_req;
      end else if (ak2_q) begin
        req_q <= 1'b0;
      end
    end
  end

  // acknowledge back from the core, read data stable by then
  always_ff @(posedge link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      ak1_q <= 1'b0;
      ak2_q <= 1'b0;
      ak_p_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (ce_link_q) begin
      ak1_q <= ack_q;
      ak2_q <= ak1_q;
      ak_p_q <= ak2_q;
      if (ack_rise && !req_word_q.we) begin
        rdata_q <= rdata_sys_q;
      end
    end
  end
  assign ack_rise = ak2_q & ~ak_p_q;

  // ready, strobe mode only: reads after the core answers, writes at once since they post
  assign rdy_ev = (mode == MODE_STROBE) & ((ack_rise & ~req_word_q.we) | (wr_fall & cs_act));
  assign rdy_set = pin_f.early ? rdy_ev : rdy_arm_q;
  always_ff @(posedge link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      rdy_arm_q <= 1'b0;
      ready_n_q <= READY_RST;
    end else if (ce_link_q) begin
      rdy_arm_q <= rdy_ev;
      if (pin_f.rd_n && pin_f.wr_n) begin
        ready_n_q <= 1'b1;
      end else if (rdy_set) begin
        ready_n_q <= 1'b0;
      end
    end
  end
  assign ready_n = ready_n_q;

  // drive window follows the read strobe of the chosen mode
  always_comb begin
    case (mode)
      MODE_MUX: rd_act = ~pin_f.rd_n & sel_q;
      MODE_STROBE: rd_act = ~pin_f.rd_n & ~pin_f.cs_n;
      MODE_ECLK: rd_act = pin_f.eclk & ~pin_f.cs_n & pin_f.rw;
      default: rd_act = 1'b0;
    endcase
  end
  assign data_oe = rd_act;
  assign data_o = rdata_q;

  // core side: request synchroniser; ack follows the request level
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      rq1_q <= 1'b0;
      rq2_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (ce) begin
      rq1_q <= req_q;
      rq2_q <= rq1_q;
      ack_q <= rq2_q;
    end
  end
  assign rq_rise = rq2_q & ~ack_q;

  // one access per request; req_word_q is held while req is up
  always_ff @(posedge clk_sys) begin
    if (ce && rq_rise && req_word_q.we) begin
      mem[req_word_q.addr] <= req_word_q.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      rdata_sys_q <= 8'h00;
    end else if (ce && rq_rise && !req_word_q.we) begin
      rdata_sys_q <= mem[req_word_q.addr];
    end
  end

  // quarter rate host clock in the core domain; holds its level while ce is low
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      div_q <= 2'h0;
      clk_out_q <= CLKOUT_RST;
    end else if (ce) begin
      div_q <= (div_q == CLKDIV_LAST) ? 2'h0 : div_q + 2'h1;
      if (div_q == CLKDIV_LAST) begin
        clk_out_q <= ~clk_out_q;
      end
    end
  end
  assign quarter_rate_clock_out = clk_out_q;

  localparam int RdMax = RD_DATA_MAX_CYC;

  read_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_sys_n || !ce)
    rq_rise && !req_word_q.we |-> ##[1:RdMax] (ack_q && rdata_sys_q == mem[req_word_q.addr]))
    else $error("read data late");
  write_once_a: assert property (@(posedge clk_sys) disable iff (!rst_sys_n || !ce)
    rq_rise && req_word_q.we |=> mem[$past(req_word_q.addr)] == $past(req_word_q.wdata))
    else $error("write not stored");
  sequence clk_edge_s;
    $changed(quarter_rate_clock_out) ##1 $stable(quarter_rate_clock_out);
  endsequence
  clk_div_a: assert property (@(posedge clk_sys) disable iff (!rst_sys_n || !ce)
    clk_edge_s |=> $changed(quarter_rate_clock_out)) else $error("host clock not quarter rate");
  ale_latch_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    mode == MODE_MUX && ale_fall |=> lo_addr_q == $past(pin_p_q.dbus)) else $error("low addr");
  cs_decode_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    mode == MODE_MUX && ale_fall |=> sel_q == ($past(pin_p_q.abus[15:13]) == CS_BASE))
    else $error("select decode");
  write_launch_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    mode == MODE_STROBE && !busy && cs_act && wr_rise
    |=> req_q && req_word_q.we && req_word_q.wdata == $past(pin_f.dbus)) else $error("write launch");
  ready_norm_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    rdy_ev && !pin_f.early ##1 !(pin_f.rd_n && pin_f.wr_n) |=> !ready_n) else $error("ready late");
  ready_early_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    rdy_ev && pin_f.early && !(pin_f.rd_n && pin_f.wr_n) |=> !ready_n) else $error("early ready");
  ready_release_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    pin_f.rd_n && pin_f.wr_n |=> ready_n) else $error("ready not withdrawn");
  data_hiz_a: assert property (@(posedge link_clk) disable iff (!rst_l_n)
    pin_f.rd_n && mode != MODE_ECLK |-> !data_oe) else $error("bus driven without read");
  eclk_read_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    mode == MODE_ECLK && !busy && cs_act && e_rise && pin_f.rw |=> req_q && !req_word_q.we)
    else $error("E read launch");
  eclk_write_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    mode == MODE_ECLK && !busy && cs_act && e_fall && !pin_f.rw
    |=> req_word_q.we && req_word_q.wdata == $past(pin_f.dbus)) else $error("E write launch");
  mode_ignore_a: assert property (@(posedge link_clk) disable iff (!rst_l_n || !ce_link_q)
    mode == MODE_STROBE && !rd_fall && !wr_rise && !req_q |=> !req_q) else $error("stray launch");
endmodule // hbi_host_port
`default_nettype wire

/* File: hbi_pin_filter.sv */
// hbi_pin_filter: three-flop synchroniser with agreement filter for pins.
// assumes inputs are asynchronous to clk; en freezes all stages.
`timescale 1ns/100ps
`default_nettype none
module hbi_pin_filter
  import hbi_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // sampling clock
  input wire logic rst_n, // async reset, active low
  input wire logic en, // clock enable
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // filtered levels
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a bit only moves once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q <= RST_VAL;
    end else if (en) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
  end
endmodule // hbi_pin_filter
`default_nettype wire

/* File: hbi_pkg.sv */
// hbi_pkg: shared constants and types of the multimode host bus interface.
// assumes a 10 MHz core clock; the host side runs on its own link clock.
package hbi_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int ABUS_W = 16;
  localparam int LO_W = 8;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam logic [2:0] CS_BASE = 3'h0;

  // timing unit is one core clock period
  localparam int SYS_CLK_NS = 100;
  localparam int T_NS = SYS_CLK_NS;
  localparam int RD_DATA_MAX_NS = 4 * T_NS + 27;
  localparam int RD_DATA_MAX_CYC = (RD_DATA_MAX_NS / SYS_CLK_NS) < 1 ? 1
                                 : (RD_DATA_MAX_NS / SYS_CLK_NS);
  localparam int RDY_NORM_MAX_NS = 5 * T_NS + 25;
  localparam int RDY_EARLY_MAX_NS = 4 * T_NS + 25;
  localparam int HOST_WR_GAP_T = 6;
  localparam int HOST_CS_WR_T = 4;
  localparam int ECLK_RATIO_MIN = 10;

  // quarter rate clock: toggle every second core cycle
  localparam int CLKOUT_RATIO = 4;
  localparam logic [1:0] CLKDIV_LAST = 2'(CLKOUT_RATIO / 2 - 1);
  localparam logic CLKOUT_RST = 1'b0;
  localparam logic READY_RST = 1'b1;

  typedef enum logic [1:0] {
    MODE_MUX = 2'b00,
    MODE_STROBE = 2'b01,
    MODE_ECLK = 2'b10
  } hbi_mode_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hbi_req_t;

  typedef struct packed {
    logic [1:0] mode;
    logic early;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic rw;
    logic eclk;
    logic [ABUS_W-1:0] abus;
    logic [DATA_W-1:0] dbus;
  } hbi_pins_t;

  // idle bus: strobes and select inactive
  localparam hbi_pins_t PINS_IDLE = '{mode: 2'h0, early: 1'b0, ale: 1'b0, rd_n: 1'b1,
    wr_n: 1'b1, cs_n: 1'b1, rw: 1'b1, eclk: 1'b0, abus: 16'h0000, dbus: 8'h00};
endpackage

/* File: multimode_host_bus_interface_bench.sv */
// multimode_host_bus_interface_bench: self-checking bench of the host port.
// assumes the host model drives every pin on link_clk; straps set in reset.
`timescale 1ns/100ps
`default_nettype none
module multimode_host_bus_interface_bench
  import hbi_pkg::*;
();
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [DATA_W-1:0] data_o;
  logic data_oe;
  logic ready_n;
  logic qclk;
  wire logic [DATA_W-1:0] data_i;
  hbi_pins_t pins;
  int n_mismatch = 0;
  int n_checks = 0;
  int oe_run = 0;
  int n;
  int rdy;
  int rel;
  int rdy_norm;
  logic [7:0] q;
  logic oe;

  // core clock 100 ns, link clock 125 ns with an unrelated phase
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end

  // shared data wire: device level while it drives, else the host's
  assign data_i = data_oe ? data_o : pins.dbus;

  hbi_host_port u_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .link_clk(link_clk),
    .mode_sel(pins.mode),
    .early_ready(pins.early),
    .ale(pins.ale),
    .read_strobe_n(pins.rd_n),
    .write_strobe_n(pins.wr_n),
    .chip_sel_n(pins.cs_n),
    .rw(pins.rw),
    .e_clock(pins.eclk),
    .address_bus(pins.abus),
    .data_i(data_i),
    .data_o(data_o),
    .data_oe(data_oe),
    .ready_n(ready_n),
    .quarter_rate_clock_out(qclk)
  );

  hbi_host_model u_host (
    .link_clk(link_clk),
    .ready_n(ready_n),
    .data_oe(data_oe),
    .data_o(data_o),
    .pins(pins)
  );

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bus must be let go within a few filter cycles of the read strobe rising
  always @(posedge link_clk) begin
    if (data_oe === 1'b1 && pins.rd_n && pins.mode != MODE_ECLK) oe_run <= oe_run + 1;
    else oe_run <= 0;
    if (oe_run == 5) chk("oe_idle", 16'h0000, 16'h0001);
  end

  // reset with new straps; straps never move while the port runs
  task automatic rst(input logic [1:0] m, input logic e);
    reset_n = 1'b0;
    u_host.strap(m, e);
    repeat (16) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    repeat (12) @(posedge link_clk);
  endtask

  task automatic t_reset();
    repeat (16) @(posedge clk_sys);
    #2;
    chk("oe_rst", 16'h0000, 16'(data_oe));
    chk("rdy_rst", 16'h0001, 16'(ready_n));
    chk("dat_rst", 16'h0000, 16'(data_o));
    reset_n = 1'b1;
    for (n = 0; n < 20 && qclk !== 1'b1; n++) @(negedge clk_sys);
    if (n == 20) begin
      chk("qclk_run", 16'h0001, 16'h0000);
      end_sim();
    end
    for (n = 0; n < 8 && qclk === 1'b1; n++) @(negedge clk_sys);
    chk("qclk_hi", 16'h0002, 16'(n));
    for (n = 0; n < 8 && qclk === 1'b0; n++) @(negedge clk_sys);
    chk("qclk_lo", 16'h0002, 16'(n));
    $display("t_reset done");
  endtask

  // strobe mode: posted writes, reads with ready, then early ready
  task automatic t_strobe();
    rst(MODE_STROBE, 1'b0);
    u_host.acc(1'b1, 16'h0123, 8'h5A, q, rdy_norm, rel, oe);
    chk("wr_oe", 16'h0000, 16'(oe));
    chk("wr_rel", 16'h0001, 16'(rel < 6));
    u_host.acc(1'b1, 16'h0124, 8'hA5, q, rdy, rel, oe);
    u_host.acc(1'b0, 16'h0123, 8'h00, q, rdy, rel, oe);
    chk("rd_dat", 16'h005A, 16'(q));
    chk("rd_oe", 16'h0001, 16'(oe));
    // filter, crossing and normal ready delay put ready at host edge 10 or 11
    chk("rd_rdy", 16'h0001, 16'(rdy > 0 && rdy <= 12));
    chk("rd_rel", 16'h0001, 16'(rel > 0 && rel < 6));
    u_host.acc(1'b0, 16'h0124, 8'h00, q, rdy, rel, oe);
    chk("rd_dat2", 16'h00A5, 16'(q));
    rst(MODE_STROBE, 1'b1);
    u_host.acc(1'b1, 16'h0125, 8'h3C, q, rdy, rel, oe);
    chk("rdy_early", 16'h0001, 16'(rdy_norm - rdy));
    $display("t_strobe done");
  endtask

  // mux mode: foreign high address must not select the device
  task automatic t_mux();
    rst(MODE_MUX, 1'b0);
    u_host.acc(1'b1, 16'h0456, 8'h3C, q, rdy, rel, oe);
    u_host.acc(1'b1, 16'h2456, 8'hC3, q, rdy, rel, oe);
    u_host.acc(1'b0, 16'h0456, 8'h00, q, rdy, rel, oe);
    chk("mux_dat", 16'h003C, 16'(q));
    chk("mux_rdy", 16'hFFFF, 16'(rdy));
    $display("t_mux done");
  endtask

  // E clock mode at top address, then unused mode leaves memory alone
  task automatic t_eclk();
    rst(MODE_ECLK, 1'b0);
    u_host.acc(1'b1, 16'h1FFF, 8'h96, q, rdy, rel, oe);
    u_host.acc(1'b0, 16'h1FFF, 8'h00, q, rdy, rel, oe);
    chk("e_dat", 16'h0096, 16'(q));
    chk("e_oe", 16'h0001, 16'(oe));
    chk("e_rdy", 16'hFFFF, 16'(rdy));
    rst(2'b11, 1'b0);
    u_host.acc(1'b1, 16'h1FFF, 8'h69, q, rdy, rel, oe);
    u_host.acc(1'b0, 16'h1FFF, 8'h00, q, rdy, rel, oe);
    chk("off_oe", 16'h0000, 16'(oe));
    chk("off_rdy", 16'hFFFF, 16'(rdy));
    rst(MODE_ECLK, 1'b0);
    u_host.acc(1'b0, 16'h1FFF, 8'h00, q, rdy, rel, oe);
    chk("off_dat", 16'h0096, 16'(q));
    $display("t_eclk done");
  endtask

  initial begin
    t_reset();
    t_strobe();
    t_mux();
    t_eclk();
    end_sim();
  end
endmodule // multimode_host_bus_interface_bench
`default_nettype wire
